// [rtl/supply_supervisor_defines.svh]
// timing counts and counter width for the supply supervisor
`ifndef SUPPLY_SUPERVISOR_DEFINES_SVH
`define SUPPLY_SUPERVISOR_DEFINES_SVH
// Overview of operation
// RL1 - the pre-drivers stay off while the 5 V undervoltage flag is set.
// RL2 - a rising 5 V undervoltage flag raises the request if enabled.
// RL3 - a 5 V overvoltage disconnects that supply while it lasts.
// RL4 - a long core supply dip asserts power-on reset after a fixed delay.
// RL5 - the pre-driver regulator stays off while power-on reset is active.
// RL6 - a debug pin high in reset turns the regulator on in bootstrap.
// RL7 - with debug as I/O, select 0 keeps the regulator on in bootstrap.
// RL8 - the host waits 100 us after the first reset release to transfer.
// RL9 - the host waits 30 us after each later reset release to transfer.
// RL10 - the host keeps the serial clock at or below 12.5 MHz.
// RL11 - the host allows one clock period from select low to first rise.
// RL12 - the host allows one clock period from last fall to select high.
// RL13 - supply monitor indications are synchronised before they are used.
`define CLK_PERIOD_NS 10
`define POR_QUAL_NS 1000
`define POR_QUAL_CYC ((`POR_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_DELAY_NS 1000
`define POR_DELAY_CYC ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPI_FIRST_WAIT_US 100
`define SPI_NEXT_WAIT_US 30
`define SPI_SCLK_MAX_KHZ 12500
`define CNT_W 8
`endif

// [rtl/supply_supervisor_pkg.sv]
// types for the supply supervisor
package supply_supervisor_pkg;
  typedef enum logic [2:0] {
    POR_RUN = 3'b001,
    POR_QUAL = 3'b010,
    POR_DELAY = 3'b100
  } por_state_t;
endpackage : supply_supervisor_pkg

// [rtl/supply_supervisor_reset.sv]
// supply supervision and power-on reset sequencing
`timescale 1ns/10ps
`include "supply_supervisor_defines.svh"
module supply_supervisor_reset
  import supply_supervisor_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // analog monitor indications, asynchronous
  input wire logic supply5_uv_raw,
  input wire logic supply5_ov_raw,
  input wire logic core_uv_raw,
  // pins
  input wire logic external_reset_n,
  input wire logic debug_pin,
  input wire logic driver_enable_in,
  // configuration
  input wire logic supply5_uv_irq_en,
  input wire logic ext_regulator_sel,
  input wire logic bootstrap_phase,
  // status and control
  output logic supply5_undervoltage_flag,
  output logic supply5_disconnect,
  output logic power_on_reset_n,
  output logic predriver_enable,
  output logic predriver_reg_on,
  output logic interrupt_request_n
);
  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  // reset value treats supplies as bad until proven good
  wire logic uv5_s;
  wire logic ov5_s;
  wire logic core_uv_s;
  wire logic ext_rst_n_s;
  wire logic debug_s;
  wire logic drv_en_s;
  supply_sync_stage #(
    .RESET_VAL(1'b1)
  ) uv5_sync (
    .clk(clk),
    .rst(rst),
    .async_in(supply5_uv_raw),
    .sync_out(uv5_s)
  );
  supply_sync_stage #(
    .RESET_VAL(1'b1)
  ) ov5_sync (
    .clk(clk),
    .rst(rst),
    .async_in(supply5_ov_raw),
    .sync_out(ov5_s)
  );
  supply_sync_stage #(
    .RESET_VAL(1'b1)
  ) core_uv_sync (
    .clk(clk),
    .rst(rst),
    .async_in(core_uv_raw),
    .sync_out(core_uv_s)
  );
  supply_sync_stage #(
    .RESET_VAL(1'b1)
  ) ext_rst_sync (
    .clk(clk),
    .rst(rst),
    .async_in(external_reset_n),
    .sync_out(ext_rst_n_s)
  );
  supply_sync_stage #(
    .RESET_VAL(1'b1)
  ) debug_sync (
    .clk(clk),
    .rst(rst),
    .async_in(debug_pin),
    .sync_out(debug_s)
  );
  // drivers stay disabled until their enable pin has been seen
  supply_sync_stage #(
    .RESET_VAL(1'b0)
  ) drv_en_sync (
    .clk(clk),
    .rst(rst),
    .async_in(driver_enable_in),
    .sync_out(drv_en_s)
  );
  // ------------------------------------------------------------
  // power-on reset sequencer
  // ------------------------------------------------------------
  por_state_t state_q, state_d;
  logic [`CNT_W-1:0] cnt_q, cnt_d;
  logic por_n_q, por_n_d;
  localparam logic [`CNT_W-1:0] QUAL_LAST = `CNT_W'(`POR_QUAL_CYC - 1);
  localparam logic [`CNT_W-1:0] DELAY_LAST = `CNT_W'(`POR_DELAY_CYC - 1);
  wire logic cnt_qual_done = (cnt_q == QUAL_LAST);
  wire logic cnt_delay_done = (cnt_q == DELAY_LAST);
  wire logic [`CNT_W-1:0] cnt_inc = cnt_q + `CNT_W'(1);
  always_comb begin
    state_d = state_q;
    cnt_d = `CNT_W'(0);
    por_n_d = por_n_q;
    unique case (state_q)
      POR_RUN: begin
        if (core_uv_s) begin
          state_d = POR_QUAL;
        end else begin
          por_n_d = 1'b1;
        end
      end
      POR_QUAL: begin
        // short dips below the threshold do not reset the core
        if (!core_uv_s) begin
          state_d = POR_RUN;
        end else if (cnt_qual_done) begin
          state_d = POR_DELAY; // RL4
        end else begin
          cnt_d = cnt_inc;
        end
      end
      POR_DELAY: begin
        if (cnt_delay_done) begin
          por_n_d = 1'b0; // RL4
          state_d = POR_RUN;
        end else begin
          cnt_d = cnt_inc;
        end
      end
      default: begin
        state_d = POR_RUN;
        por_n_d = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= POR_RUN;
      cnt_q <= `CNT_W'(0);
      por_n_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      por_n_q <= por_n_d;
    end
  end
  // ------------------------------------------------------------
  // debug strap, caught while reset is held
  // ------------------------------------------------------------
  logic strap_q;
  wire logic in_reset = !por_n_q || !ext_rst_n_s;
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_q <= 1'b1;
    end else if (in_reset) begin
      strap_q <= debug_s; // RL6
    end
  end
  // ------------------------------------------------------------
  // flags, interrupt and outputs
  // ------------------------------------------------------------
  logic uv5_q;
  logic ov5_q;
  logic irq_q;
  logic pre_en_q;
  logic reg_on_q;
  wire logic uv5_rise = uv5_s && !uv5_q;
  wire logic irq_d = (uv5_rise && supply5_uv_irq_en) || // RL2
                     (irq_q && uv5_s);
  // bootstrap regulator: strap high or internal select, never in power-on reset
  wire logic boot_on = bootstrap_phase && // RL6 RL7
                       (strap_q || !ext_regulator_sel);
  wire logic reg_d = por_n_q && (boot_on || !ext_regulator_sel); // RL5
  wire logic pre_d = drv_en_s && !uv5_s && por_n_q && ext_rst_n_s; // RL1
  always_ff @(posedge clk) begin
    if (rst) begin
      uv5_q <= 1'b1;
      ov5_q <= 1'b1;
      irq_q <= 1'b0;
      pre_en_q <= 1'b0;
      reg_on_q <= 1'b0;
    end else begin
      uv5_q <= uv5_s;
      ov5_q <= ov5_s; // RL3
      irq_q <= irq_d;
      pre_en_q <= pre_d;
      reg_on_q <= reg_d;
    end
  end
  assign supply5_undervoltage_flag = uv5_q;
  assign supply5_disconnect = ov5_q; // RL3
  assign power_on_reset_n = por_n_q;
  assign predriver_enable = pre_en_q;
  assign predriver_reg_on = reg_on_q;
  assign interrupt_request_n = !irq_q;
endmodule : supply_supervisor_reset

// ------------------------------------------------------------
// two-flop synchroniser for one asynchronous input
// ------------------------------------------------------------
module supply_sync_stage #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous input and its synchronised copy
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic sync_q;
  // only the second flop is read, the first may be metastable
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_in; // RL13
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule : supply_sync_stage

// [testbench/supply_supervisor_properties.sv]
// port checker for the supply supervisor
`timescale 1ns/10ps
module supply_supervisor_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // monitor and pin inputs
  input wire logic supply5_uv_raw,
  input wire logic supply5_ov_raw,
  input wire logic core_uv_raw,
  input wire logic external_reset_n,
  input wire logic debug_pin,
  input wire logic driver_enable_in,
  // configuration
  input wire logic supply5_uv_irq_en,
  input wire logic ext_regulator_sel,
  input wire logic bootstrap_phase,
  // outputs of the supervisor
  input wire logic supply5_undervoltage_flag,
  input wire logic supply5_disconnect,
  input wire logic power_on_reset_n,
  input wire logic predriver_enable,
  input wire logic predriver_reg_on,
  input wire logic interrupt_request_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_flag_sync: assert property (supply5_uv_raw [*4]
    |-> supply5_undervoltage_flag) else $error("late flag");
  chk_ov_set: assert property (supply5_ov_raw [*4]
    |-> supply5_disconnect) else $error("no disconnect");
  chk_ov_clear: assert property ((!supply5_ov_raw && power_on_reset_n)
    [*4] |-> !supply5_disconnect) else $error("stuck disconnect");
  chk_uv_gates: assert property (supply5_undervoltage_flag [*2]
    |-> !predriver_enable) else $error("driver on in uv");
  chk_irq_raise: assert property (supply5_uv_irq_en &&
    $rose(supply5_undervoltage_flag) |-> ##[0:1] !interrupt_request_n)
    else $error("no irq");
  chk_por_qual: assert property ($fell(power_on_reset_n)
    |-> $past(core_uv_raw, 150)) else $error("early por");
  chk_por_reg: assert property (!power_on_reset_n [*2]
    |-> !predriver_reg_on) else $error("reg on in por");
  chk_reg_int: assert property ((power_on_reset_n && !ext_regulator_sel)
    [*2] |-> predriver_reg_on) else $error("reg off");
  cover property ($fell(interrupt_request_n));
  cover property ($fell(power_on_reset_n));
  cover property ($rose(supply5_disconnect));
  cover property ($rose(predriver_reg_on));
endmodule : supply_supervisor_properties
bind supply_supervisor_reset supply_supervisor_properties chk (.*);

// [testbench/supply_host_model.sv]
// host model: reset pin, debug strap and transfer wait
`timescale 1ns/10ps
module supply_host_model (
  // bench control
  input wire logic clk,
  input wire logic hold_n,
  input wire logic strap_low,
  // pins toward the device
  output logic external_reset_n,
  output logic debug_pin,
  output logic chip_select_n,
  output logic spi_clk,
  // status toward the bench
  output logic spi_ready,
  output logic frame_done
);
  int wait_q = 0;
  bit first_q = 1'b1;
  // unused strap reads high through the weak pull-up
  assign debug_pin = ~strap_low;
  assign spi_ready = external_reset_n && wait_q == 0;
  initial external_reset_n = 1'b0;
  always @(posedge clk) begin
    external_reset_n <= hold_n;
    if (!external_reset_n && hold_n) begin
      wait_q <= first_q ? 32'h2710 : 32'hBB8;
      first_q <= 1'b0;
    end else if (wait_q != 0) begin
      wait_q <= wait_q - 1;
    end
  end
  // one frame once the wait has run out; the clock stands still outside it
  initial begin
    chip_select_n = 1'b1;
    spi_clk = 1'b0;
    frame_done = 1'b0;
    while (spi_ready !== 1'b1) @(posedge clk);
    chip_select_n <= 1'b0;
    #160;
    repeat (8) begin
      // 160 ns period stays below the 12.5 MHz ceiling
      spi_clk <= 1'b1;
      #80;
      spi_clk <= 1'b0;
      #80;
    end
    #80;
    chip_select_n <= 1'b1;
    frame_done <= 1'b1;
  end
endmodule : supply_host_model

// [testbench/tb_supply_supervisor_reset.sv]
// self-checking bench for the supply supervisor
`timescale 1ns/10ps
module tb_supply_supervisor_reset;
  logic clk = 0, rst = 1, uv = 0, ov = 0, cuv = 0, ien = 1, sel = 1;
  logic hold_n = 0, strap_low = 0, external_reset_n, debug_pin, spi_ready;
  logic boot = 1, drv = 1, chip_select_n, spi_clk, frame_done;
  logic flag, disc, por_n, pre, reg_on, irq_n;
  int fail_count = 0, comparisons = 0, cyc = 0;
  always #5 clk = ~clk;
  supply_host_model host (.*);
  supply_supervisor_reset dut (.*, .supply5_uv_raw(uv), .supply5_ov_raw(ov),
    .core_uv_raw(cuv), .driver_enable_in(drv), .supply5_uv_irq_en(ien),
    .ext_regulator_sel(sel), .bootstrap_phase(boot),
    .supply5_undervoltage_flag(flag), .supply5_disconnect(disc),
    .power_on_reset_n(por_n), .predriver_enable(pre),
    .predriver_reg_on(reg_on), .interrupt_request_n(irq_n));
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task chk(input logic got, input logic exp);
    #1;
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %b want %b", $time, got, exp);
    end
  endtask : chk
  task finish_test;
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      finish_test;
    end
  end
  initial begin
    wt(12);
    rst <= 0;
    hold_n <= 1;
    chk(reg_on, 0);
    wt(20);
    chk(por_n, 1);
    chk(reg_on, 1);
    chk(spi_ready, 0);
    boot <= 0;
    wt(2);
    chk(reg_on, 0);
    boot <= 1;
    drv <= 0;
    wt(4);
    chk(pre, 0);
    chk(reg_on, 1);
    drv <= 1;
    wt(4);
    chk(pre, 1);
    uv <= 1;
    wt(2);
    chk(flag, 0);
    wt(2);
    chk(irq_n, 0);
    chk(pre, 0);
    uv <= 0;
    wt(5);
    chk(pre, 1);
    ien <= 0;
    uv <= 1;
    wt(5);
    chk(irq_n, 1);
    uv <= 0;
    ov <= 1;
    wt(4);
    chk(disc, 1);
    ov <= 0;
    cuv <= 1;
    wt(50);
    cuv <= 0;
    wt(250);
    chk(por_n, 1);
    cuv <= 1;
    wt(300);
    chk(reg_on, 0);
    chk(por_n, 0);
    cuv <= 0;
    strap_low <= 1;
    hold_n <= 0;
    wt(10);
    hold_n <= 1;
    wt(10);
    chk(reg_on, 0);
    chk(spi_ready, 0);
    sel <= 0;
    wt(3);
    chk(reg_on, 1);
    // no transfer may start before the host wait has run out
    for (int i = 0; i < 4000 && !spi_ready; i++) wt(1);
    chk(spi_ready, 1);
    wt(160);
    chk(frame_done, 1);
    chk(chip_select_n, 1);
    chk(spi_clk, 0);
    finish_test;
  end
endmodule : tb_supply_supervisor_reset
